// >>> core/qhp_consts.svh
// constants of the quad uart host port: widths, timing counts, reset values
// assumes a single 40 MHz clock; included by its bare name
`ifndef QHP_CONSTS_SVH
`define QHP_CONSTS_SVH

// bus shape
`define QHP_NUM_CHAN 4
`define QHP_DATA_W 8
`define QHP_ADDR_W 3
`define QHP_CHAN_AW 2

// timing: clock period and the shortest reset pulse that counts
`define QHP_CLK_NS 25
`define QHP_RST_MIN_NS 40
`define QHP_RST_MIN_CYC ((`QHP_RST_MIN_NS + `QHP_CLK_NS - 1) / `QHP_CLK_NS)
`define QHP_RST_CNT_W 4

// reset values of the status pins
`define QHP_INT_RST 1'b0
`define QHP_RDY_N_RST 1'b1
`define QHP_STAT_RST 1'b1

// line status bit positions carried by the room and idle outputs
`define QHP_STAT_TX_ROOM_BIT 5
`define QHP_STAT_TX_IDLE_BIT 6

`endif

// >>> core/qhp_pkg.sv
// types shared by the quad uart host port modules
// assumes nothing beyond the constants header
package qhp_pkg;

  // bus cycle tracker; idle -> read -> idle and idle -> write -> idle
  typedef enum logic [1:0] {
    QHP_IDLE = 2'b00,
    QHP_READ = 2'b01,
    QHP_WRITE = 2'b10
  } qhp_bus_state_type;

endpackage

// >>> core/qhp_sel_if.sv
// channel selection carrier between the host port top and its decoder
// assumes one clock domain; purely combinational signals
`timescale 1ns/100ps

interface qhp_sel_if;
  logic strobe_mode;
  logic [3:0] cs_n;
  logic chip_sel_n;
  logic [1:0] chan_addr;
  logic [3:0] sel;
  logic any;
  logic multi;

  modport decoder (
    input strobe_mode,
    input cs_n,
    input chip_sel_n,
    input chan_addr,
    output sel,
    output any,
    output multi
  );

  modport user (
    output strobe_mode,
    output cs_n,
    output chip_sel_n,
    output chan_addr,
    input sel,
    input any,
    input multi
  );
endinterface

// >>> core/qhp_chan_decode.sv
// channel select decoder for both bus styles
// assumes the pin levels on the interface are already synchronous
`timescale 1ns/100ps

module qhp_chan_decode (
  // selection carrier
  qhp_sel_if.decoder sel_if
);

  wire [3:0] strobe_sel;
  wire [3:0] rw_sel;
  wire [3:0] sel_m1;

  // strobe style: each low select picks its own channel, all low picks all
  assign strobe_sel = ~sel_if.cs_n; // RL6 RL7
  // read/write style: one select plus two channel address bits
  assign rw_sel = sel_if.chip_sel_n ? 4'h0 : (4'h1 << sel_if.chan_addr); // RL8
  // address decode only counts in read/write style
  assign sel_if.sel = sel_if.strobe_mode ? strobe_sel : rw_sel; // RL5 RL9
  assign sel_if.any = |sel_if.sel;
  assign sel_m1 = sel_if.sel - 4'h1;
  assign sel_if.multi = |(sel_if.sel & sel_m1);

endmodule

// >>> core/qhp_host_port.sv
// host side port of a four channel uart: bus cycles, channel select, reset
// qualification and the per-channel interrupt and ready pins
// assumes all pins are synchronous to ref_clk_i; channel cores sit behind reg_*
//
// Operation
// RL1: host port has 8 data bits, 3 register address lines and strobes.
// RL2: a bus cycle is driven only by selects and strobes, no baud clock.
// RL3: four channels share one data bus; only the selected one answers.
// RL4: reset pulse longer than 40 ns resets all channels; host supplies it.
// RL5: bus mode pin high gives strobe style, low gives read/write style.
// RL6: in strobe style each low channel select picks channel A to D.
// RL7: all selects low write every channel; host never reads multiple channels.
// RL8: read/write style: select low, two address bits pick channel A to D.
// RL9: channel address bits count only in read/write style.
// RL10: fifo off: transmit interrupt low with byte held, high when empty.
// RL11: fifo on: transmit interrupt high below trigger, low above it.
// RL12: fifo off: receive interrupt high with one byte, low with none.
// RL13: fifo on: receive interrupt high above trigger, low below it.
// RL14: fifo control bit 3 picks block mode; cleared means single character.
// RL15: block mode only changes the receive and transmit ready pins.
// RL16: fifo off: receive ready low with a byte held, high with none.
// RL17: fifo on, no block: receive ready low while fifo holds a byte.
// RL18: block: receive ready falls at trigger or timeout, rises when empty.
// RL19: fifo off: transmit ready low when holding register empty.
// RL20: fifo on, no block: transmit ready low only while fifo empty.
// RL21: block: transmit ready low with free space, high only when full.
// RL22: line status bits 5 and 6 show transmit room and transmitter idle.
// RL23: read/write style reset pin is active low, 40 ns minimum.
// RL24: during reset serial output held high, input ignored, outputs reset.
// RL25: data bus driven only while a channel is selected and read.
`timescale 1ns/100ps
`include "qhp_consts.svh"

module qhp_host_port #(
  parameter int NUM_CHAN = `QHP_NUM_CHAN,
  parameter int DATA_W = `QHP_DATA_W,
  parameter int ADDR_W = `QHP_ADDR_W
) (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // device pins: mode and reset
  input wire logic mode_strobe_i,
  input wire logic reset_pin_i,
  // strobe style selects and strobes
  input wire logic chan_a_select_n_i,
  input wire logic chan_b_select_n_i,
  input wire logic chan_c_select_n_i,
  input wire logic chan_d_select_n_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  // read/write style select, direction and channel address
  input wire logic chip_select_n_i,
  input wire logic rd_wr_n_i,
  input wire logic [1:0] chan_addr_i,
  // register address and data bus, split into three signals
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  // to and from the channel cores
  output logic [ADDR_W-1:0] reg_addr_o,
  output logic [DATA_W-1:0] reg_wdata_o,
  output logic [NUM_CHAN-1:0] reg_wr_o,
  output logic [NUM_CHAN-1:0] reg_rd_o,
  output logic chan_reset_o,
  input wire logic [NUM_CHAN*DATA_W-1:0] rd_data_i,
  // per-channel state from the channel cores
  input wire logic [NUM_CHAN-1:0] fifo_en_i,
  input wire logic [NUM_CHAN-1:0] block_mode_i,
  input wire logic [NUM_CHAN-1:0] rx_held_i,
  input wire logic [NUM_CHAN-1:0] rx_at_trig_i,
  input wire logic [NUM_CHAN-1:0] rx_timeout_i,
  input wire logic [NUM_CHAN-1:0] tx_held_i,
  input wire logic [NUM_CHAN-1:0] tx_above_trig_i,
  input wire logic [NUM_CHAN-1:0] tx_full_i,
  input wire logic [NUM_CHAN-1:0] tx_shift_empty_i,
  // per-channel pins and line status bits
  output logic [NUM_CHAN-1:0] tx_int_o,
  output logic [NUM_CHAN-1:0] rx_int_o,
  output logic [NUM_CHAN-1:0] rx_avail_n_o,
  output logic [NUM_CHAN-1:0] tx_space_n_o,
  output logic [NUM_CHAN-1:0] tx_room_o,
  output logic [NUM_CHAN-1:0] tx_idle_o
);

  localparam logic [`QHP_RST_CNT_W-1:0] RST_MIN_CYC = `QHP_RST_CNT_W'(`QHP_RST_MIN_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // channel selection

  qhp_sel_if sel_if ();

  assign sel_if.strobe_mode = mode_strobe_i;
  assign sel_if.cs_n = {chan_d_select_n_i, chan_c_select_n_i, chan_b_select_n_i, chan_a_select_n_i};
  assign sel_if.chip_sel_n = chip_select_n_i;
  assign sel_if.chan_addr = chan_addr_i;

  qhp_chan_decode u_decode (
    .sel_if(sel_if.decoder)
  );

  ////////////////////////////////////////////////////////////////////////////
  // device reset qualification

  logic [`QHP_RST_CNT_W-1:0] rst_cnt;
  wire rst_pin_act;
  wire [`QHP_RST_CNT_W-1:0] rst_cnt_inc;
  wire [`QHP_RST_CNT_W-1:0] next_rst_cnt;
  wire next_chan_reset;

  // pin polarity follows the bus style
  assign rst_pin_act = mode_strobe_i ? reset_pin_i : ~reset_pin_i; // RL4 RL23
  assign rst_cnt_inc = rst_cnt + `QHP_RST_CNT_W'(1);
  // saturating count so a long pulse cannot wrap and drop the reset
  assign next_rst_cnt = !rst_pin_act ? '0 : (rst_cnt >= RST_MIN_CYC) ? rst_cnt : rst_cnt_inc;
  // glitches shorter than the minimum never reach the channels
  assign next_chan_reset = rst_pin_act && (next_rst_cnt >= RST_MIN_CYC); // RL4 RL23

  // width counter and the qualified reset to the channel cores
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rst_cnt <= '0;
      chan_reset_o <= 1'b1;
    end else if (clk_en_i) begin
      rst_cnt <= next_rst_cnt;
      chan_reset_o <= next_chan_reset; // RL24
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus cycle tracking

  qhp_pkg::qhp_bus_state_type state;
  qhp_pkg::qhp_bus_state_type next_state;
  wire read_req;
  wire write_req;
  wire start_rd;
  wire start_wr;
  wire [1:0] chan_idx;
  wire [DATA_W-1:0] rd_mux;

  // direction from the strobes or from the single direction pin
  assign read_req = sel_if.any && (mode_strobe_i ? !read_strobe_n_i : rd_wr_n_i); // RL5 RL2
  assign write_req = sel_if.any && (mode_strobe_i ? !write_strobe_n_i : !rd_wr_n_i); // RL5 RL2
  assign start_wr = (state == qhp_pkg::QHP_IDLE) && write_req && !next_chan_reset;
  // a read with several channels selected is not serviced at all
  assign start_rd = (state == qhp_pkg::QHP_IDLE) && read_req && !write_req && !sel_if.multi
    && !next_chan_reset; // RL7
  assign chan_idx = {sel_if.sel[3] | sel_if.sel[2], sel_if.sel[3] | sel_if.sel[1]};
  assign rd_mux = rd_data_i[{chan_idx, 3'b000} +: DATA_W]; // RL3

  // cycle ends when its own strobe or select drops
  always_comb begin
    next_state = state;
    unique case (state)
      qhp_pkg::QHP_IDLE: begin
        if (start_wr) begin
          next_state = qhp_pkg::QHP_WRITE;
        end else if (start_rd) begin
          next_state = qhp_pkg::QHP_READ;
        end
      end
      qhp_pkg::QHP_READ: begin
        if (!read_req || sel_if.multi || next_chan_reset) begin
          next_state = qhp_pkg::QHP_IDLE;
        end
      end
      qhp_pkg::QHP_WRITE: begin
        if (!write_req || next_chan_reset) begin
          next_state = qhp_pkg::QHP_IDLE;
        end
      end
      default: begin
        next_state = qhp_pkg::QHP_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= qhp_pkg::QHP_IDLE;
    end else if (clk_en_i) begin
      state <= next_state;
    end
  end

  // one write or read pulse per cycle to the selected channels
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_wr_o <= '0;
      reg_rd_o <= '0;
    end else if (clk_en_i) begin
      reg_wr_o <= start_wr ? sel_if.sel : '0; // RL7 RL3
      reg_rd_o <= start_rd ? sel_if.sel : '0; // RL3
    end
  end

  // address and write data latched at the start of a cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_addr_o <= '0;
      reg_wdata_o <= '0;
    end else if (clk_en_i && (start_wr || start_rd)) begin
      reg_addr_o <= addr_i; // RL1
      reg_wdata_o <= data_i; // RL1
    end
  end

  // read data follows the selected channel for the length of the read
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      data_o <= '0;
      data_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      data_o <= (next_state == qhp_pkg::QHP_READ) ? rd_mux : '0;
      data_oe_o <= (next_state == qhp_pkg::QHP_READ); // RL25
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel interrupt, ready and line status pins

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      logic blk_low;
      wire blk_on;
      wire next_tx_int;
      wire next_rx_int;
      wire next_blk_low;
      wire next_rx_avail_n;
      wire next_tx_space_n;
      wire next_tx_room;
      wire next_tx_idle;

      // block mode means nothing with the fifos off
      assign blk_on = fifo_en_i[ch] && block_mode_i[ch]; // RL14
      // interrupts do not depend on block mode
      assign next_tx_int = fifo_en_i[ch] ? !tx_above_trig_i[ch] : !tx_held_i[ch]; // RL10 RL11 RL15
      assign next_rx_int = fifo_en_i[ch] ? rx_at_trig_i[ch] : rx_held_i[ch]; // RL12 RL13 RL15
      // block receive ready: falls on trigger or timeout, rises only on empty
      assign next_blk_low = (rx_at_trig_i[ch] || rx_timeout_i[ch]) ? 1'b1
        : !rx_held_i[ch] ? 1'b0 : blk_low; // RL18
      assign next_rx_avail_n = blk_on ? !next_blk_low : !rx_held_i[ch]; // RL16 RL17 RL18
      assign next_tx_space_n = blk_on ? tx_full_i[ch] : tx_held_i[ch]; // RL19 RL20 RL21
      assign next_tx_room = fifo_en_i[ch] ? !tx_full_i[ch] : !tx_held_i[ch]; // RL22
      assign next_tx_idle = !tx_held_i[ch] && tx_shift_empty_i[ch]; // RL22

      // pins forced to reset values while either reset is active
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          blk_low <= 1'b0;
          tx_int_o[ch] <= `QHP_INT_RST;
          rx_int_o[ch] <= `QHP_INT_RST;
          rx_avail_n_o[ch] <= `QHP_RDY_N_RST;
          tx_space_n_o[ch] <= `QHP_RDY_N_RST;
          tx_room_o[ch] <= `QHP_STAT_RST;
          tx_idle_o[ch] <= `QHP_STAT_RST;
        end else if (clk_en_i) begin
          blk_low <= next_chan_reset ? 1'b0 : next_blk_low;
          tx_int_o[ch] <= next_chan_reset ? `QHP_INT_RST : next_tx_int; // RL24
          rx_int_o[ch] <= next_chan_reset ? `QHP_INT_RST : next_rx_int; // RL24
          rx_avail_n_o[ch] <= next_chan_reset ? `QHP_RDY_N_RST : next_rx_avail_n; // RL24
          tx_space_n_o[ch] <= next_chan_reset ? `QHP_RDY_N_RST : next_tx_space_n; // RL24
          tx_room_o[ch] <= next_chan_reset ? `QHP_STAT_RST : next_tx_room;
          tx_idle_o[ch] <= next_chan_reset ? `QHP_STAT_RST : next_tx_idle;
        end
      end

      // block transmit ready tracks fullness one cycle later
      a_tx_block_ready: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL21
        (clk_en_i && blk_on && !next_chan_reset) |=> (tx_space_n_o[ch] == $past(tx_full_i[ch])))
        else $error("block transmit ready does not follow fifo full");

      // block receive ready stays low until the fifo empties
      a_rx_block_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL18
        (clk_en_i && blk_on && rx_at_trig_i[ch] && !next_chan_reset)
        ##1 (clk_en_i && blk_on && rx_held_i[ch] && !next_chan_reset) |=> !rx_avail_n_o[ch])
        else $error("block receive ready rose before the fifo emptied");

      // transmit interrupt against trigger level or holding register
      a_tx_int_map: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL10 RL11
        (clk_en_i && !next_chan_reset) |=>
        (tx_int_o[ch] == ($past(fifo_en_i[ch]) ? !$past(tx_above_trig_i[ch]) : !$past(tx_held_i[ch]))))
        else $error("transmit interrupt level wrong");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // checks on reset, selection and bus drive

  sequence s_pin_held;
    (clk_en_i && rst_pin_act) [*2];
  endsequence

  sequence s_write_start;
    clk_en_i && start_wr;
  endsequence

  // two cycles of an active pin reach the channels
  a_rst_qualify: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL4 RL23
    s_pin_held |=> chan_reset_o)
    else $error("reset pulse of minimum width not taken");

  // an idle pin never holds the channels in reset
  a_rst_release: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL4
    (clk_en_i && !rst_pin_act) |=> !chan_reset_o)
    else $error("channel reset without an active pin");

  // strobe style ignores the channel address bits
  a_strobe_sel: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL6 RL9
    mode_strobe_i |-> (sel_if.sel == ~sel_if.cs_n))
    else $error("strobe style select decode wrong");

  // read/write style decodes the two address bits
  a_rw_sel: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL8
    (!mode_strobe_i && !chip_select_n_i) |-> (sel_if.sel == (4'h1 << chan_addr_i)))
    else $error("read/write style select decode wrong");

  // write pulse lands on exactly the selected channels, once
  a_write_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL7 RL3
    s_write_start |=> (reg_wr_o == $past(sel_if.sel)) ##1 (reg_wr_o == 4'h0))
    else $error("write pulse wrong");

  // no drive without a single selected read
  a_bus_release: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL25 RL7
    (clk_en_i && (!read_req || sel_if.multi)) |=> !data_oe_o)
    else $error("data bus driven outside a read");

  // outputs held while the channels are in reset
  a_reset_outputs: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RL24
    (clk_en_i && next_chan_reset) |=> (tx_int_o == '0) && (rx_avail_n_o == '1) && (tx_space_n_o == '1))
    else $error("status pins not in reset state");

endmodule

// >>> verification/qhp_host_model.sv
// host processor model driving the parallel port pins of both bus styles
// assumes the port samples every pin on the rising edge of clk_i
`timescale 1ns/100ps

module qhp_host_model (
  // clock
  input wire logic clk_i,
  // bus style and device reset pins
  output logic mode_strobe_o,
  output logic reset_pin_o,
  // selects and strobes of both styles
  output logic [3:0] sel_n_o,
  output logic chip_sel_n_o,
  output logic rd_wr_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  // channel address, register address and data
  output logic [1:0] chan_addr_o,
  output logic [2:0] addr_o,
  output logic [7:0] data_o
);
  ////////////////////////////////////////////////////////////////
  // idle pins at time zero
  initial begin
    mode_strobe_o = 1'b1;
    reset_pin_o = 1'b0;
    sel_n_o = 4'hf;
    chip_sel_n_o = 1'b1;
    rd_wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    chan_addr_o = 2'h0;
    addr_o = 3'h0;
    data_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////
  // one byte transfer, held until the edge that takes it
  // a data bus not driven by us shows the inverse of its last value
  task automatic start(input logic rd, input logic [3:0] cs_n, input logic [1:0] ca,
                       input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sel_n_o <= cs_n;
    chip_sel_n_o <= mode_strobe_o | cs_n[0];
    rd_wr_n_o <= rd;
    rd_n_o <= !(mode_strobe_o & rd);
    wr_n_o <= !(mode_strobe_o & !rd);
    chan_addr_o <= ca;
    addr_o <= a;
    data_o <= rd ? ~data_o : d;
    @(posedge clk_i);
  endtask

  // release, then leave idle cycles before the next transfer
  task automatic finish();
    @(posedge clk_i);
    sel_n_o <= 4'hf;
    chip_sel_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    data_o <= ~data_o;
    repeat (2) @(posedge clk_i);
  endtask

  // style change moves the reset pin to its new idle level at once
  task automatic set_mode(input logic m);
    @(posedge clk_i);
    mode_strobe_o <= m;
    reset_pin_o <= !m;
    repeat (3) @(posedge clk_i);
  endtask

  // reset pin active for n edges; its active level equals the style pin
  task automatic pulse(input int n);
    @(posedge clk_i);
    reset_pin_o <= mode_strobe_o;
    repeat (n) @(posedge clk_i);
    reset_pin_o <= !mode_strobe_o;
  endtask
endmodule

// >>> verification/quad_uart_host_port_status_tb.sv
// bench of the quad uart host port: bus cycles, reset pin, status pins
// assumes the host model drives the pins and the bench plays the channel cores
`timescale 1ns/100ps

module quad_uart_host_port_status_tb;
  // status steps, fields {fifo, block, rx held, trig, timeout, tx held, above, full, shift empty}
  localparam logic [31:0] RD_DATA = 32'h8d4e27b1;
  localparam logic [35:0] STEPS [7] = '{36'h0f500300f, 36'hf06a0c905, 36'hff000000f,
    36'hfff34f6a9, 36'hfff00f650, 36'hff600e0f3, 36'haf9506c3f};
  logic ref_clk_i, rst_i, mode, rpin, chip_n, rdwr, rdn, wrn, doe, creset, rst_seen, seen_clr, cen;
  logic [3:0] seln, rwr, rrd, txi, rxi, ravn, tspn, room, idle, lat;
  logic [3:0] fe, bm, rh, rt, ro, th, ta, tf, se;
  logic [1:0] ca;
  logic [2:0] adr, raddr;
  logic [7:0] din, dout, rwdata, wcount;
  int mismatches, n_tests;

  ////////////////////////////////////////////////////////////////
  // 40 MHz reference clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // remembers that the channels were put in reset, even for one cycle; one writer only
  always @(posedge ref_clk_i) begin
    rst_seen <= seen_clr ? 1'b0 : (rst_seen | (creset === 1'b1));
  end

  // host on the far side and the port itself
  qhp_host_model host (
    .clk_i(ref_clk_i), .mode_strobe_o(mode), .reset_pin_o(rpin), .sel_n_o(seln),
    .chip_sel_n_o(chip_n), .rd_wr_n_o(rdwr), .rd_n_o(rdn), .wr_n_o(wrn),
    .chan_addr_o(ca), .addr_o(adr), .data_o(din)
  );
  qhp_host_port uut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(cen),
    .mode_strobe_i(mode), .reset_pin_i(rpin),
    .chan_a_select_n_i(seln[0]), .chan_b_select_n_i(seln[1]),
    .chan_c_select_n_i(seln[2]), .chan_d_select_n_i(seln[3]),
    .read_strobe_n_i(rdn), .write_strobe_n_i(wrn), .chip_select_n_i(chip_n),
    .rd_wr_n_i(rdwr), .chan_addr_i(ca), .addr_i(adr), .data_i(din),
    .data_o(dout), .data_oe_o(doe), .reg_addr_o(raddr), .reg_wdata_o(rwdata),
    .reg_wr_o(rwr), .reg_rd_o(rrd), .chan_reset_o(creset), .rd_data_i(RD_DATA),
    .fifo_en_i(fe), .block_mode_i(bm), .rx_held_i(rh), .rx_at_trig_i(rt),
    .rx_timeout_i(ro), .tx_held_i(th), .tx_above_trig_i(ta), .tx_full_i(tf),
    .tx_shift_empty_i(se), .tx_int_o(txi), .rx_int_o(rxi), .rx_avail_n_o(ravn),
    .tx_space_n_o(tspn), .tx_room_o(room), .tx_idle_o(idle)
  );

  ////////////////////////////////////////////////////////////////
  // compares; case inequality so an unknown never matches
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // a one-edge pulse must be ignored, a two-edge (50 ns) pulse must reset
  task automatic reset_case(input logic m);
    host.set_mode(m);
    seen_clr <= 1'b1;
    @(posedge ref_clk_i);
    seen_clr <= 1'b0;
    host.pulse(1);
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk1("short reset pulse", 1'b0, rst_seen);
    host.pulse(2);
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk1("reset pulse", 1'b1, rst_seen);
    chk1("reset released", 1'b0, creset);
    $display("test reset style %0d done", m);
  endtask

  // a write then a read with the same selection; expected strobes given per channel
  task automatic bus_pair(input logic m, input logic [3:0] cs_n, input logic [1:0] c,
                          input logic [3:0] wsel, input logic [3:0] rsel);
    logic [7:0] rexp;
    rexp = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (rsel[i]) begin
        rexp = RD_DATA[8*i +: 8];
      end
    end
    wcount = wcount + 8'h3b;
    host.start(1'b0, cs_n, c, wcount[2:0], wcount);
    @(negedge ref_clk_i);
    chk8("write pulse", {4'h0, wsel}, {4'h0, rwr});
    if (wsel != 4'h0) begin
      chk8("register address", {5'h00, wcount[2:0]}, {5'h00, raddr});
      chk8("write data", wcount, rwdata);
    end
    host.finish();
    @(negedge ref_clk_i);
    chk8("write pulse end", 8'h00, {4'h0, rwr});
    host.start(1'b1, cs_n, c, 3'h2, 8'h00);
    @(negedge ref_clk_i);
    chk8("read pulse", {4'h0, rsel}, {4'h0, rrd});
    chk1("bus drive", |rsel, doe);
    chk8("read data", rexp, dout);
    if (rsel != 4'h0) begin
      chk8("read address", 8'h02, {5'h00, raddr});
    end
    host.finish();
    @(negedge ref_clk_i);
    chk1("bus release", 1'b0, doe);
    chk8("idle data", 8'h00, dout);
    $display("test bus select %h done", cs_n);
  endtask

  // channel core levels applied, expected pins worked out per channel
  task automatic status_step(input logic [35:0] s);
    logic [3:0] blk;
    @(posedge ref_clk_i);
    {fe, bm, rh, rt, ro, th, ta, tf, se} <= s;
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    blk = fe & bm;
    lat = rt | ro | (lat & rh);
    chk8("tx interrupt", {4'h0, (fe & ~ta) | (~fe & ~th)}, {4'h0, txi});
    chk8("rx interrupt", {4'h0, (fe & rt) | (~fe & rh)}, {4'h0, rxi});
    chk8("rx ready", {4'h0, (blk & ~lat) | (~blk & ~rh)}, {4'h0, ravn});
    chk8("tx ready", {4'h0, (blk & tf) | (~blk & th)}, {4'h0, tspn});
    chk8("tx room", {4'h0, (fe & ~tf) | (~fe & ~th)}, {4'h0, room});
    chk8("tx idle", {4'h0, ~th & se}, {4'h0, idle});
    $display("test status %h done", s);
  endtask

  // enable low must freeze the pins although the channel levels move
  task automatic freeze_case();
    logic [3:0] held;
    held = txi;
    @(posedge ref_clk_i);
    cen <= 1'b0;
    {fe, bm, rh, rt, ro, th, ta, tf, se} <= 36'h0;
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk8("frozen tx interrupt", {4'h0, held}, {4'h0, txi});
    @(posedge ref_clk_i);
    cen <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk8("thawed tx interrupt", 8'h0f, {4'h0, txi});
    $display("test clock enable done");
  endtask

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_i = 1'b1;
    {fe, bm, rh, rt, ro, th, ta, tf, se} = 36'h0;
    lat = 4'h0;
    seen_clr = 1'b0;
    cen = 1'b1;
    wcount = 8'h00;
    mismatches = 0;
    n_tests = 0;
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    reset_case(1'b1);
    for (int ch = 0; ch < 4; ch++) begin
      bus_pair(1'b1, ~(4'h1 << ch), ~ch[1:0], 4'h1 << ch, 4'h1 << ch);
    end
    bus_pair(1'b1, 4'h0, 2'h0, 4'hf, 4'h0);
    bus_pair(1'b1, 4'hf, 2'h0, 4'h0, 4'h0);
    foreach (STEPS[i]) begin
      status_step(STEPS[i]);
    end
    freeze_case();
    reset_case(1'b0);
    for (int ch = 0; ch < 4; ch++) begin
      bus_pair(1'b0, 4'h0, ch[1:0], 4'h1 << ch, 4'h1 << ch);
    end
    bus_pair(1'b0, 4'hf, 2'h0, 4'h0, 4'h0);
    stop_test();
  end

  // cuts a hang short; the sequence needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge ref_clk_i);
    mismatches++;
    stop_test();
  end
endmodule
